// ==== inc/wdit_defs.svh ====
// Constants for the watchdog / interval timer: addresses, field positions,
// reset values, keys and timing counts. Included by the package and the design.
`ifndef WDIT_DEFS_SVH
`define WDIT_DEFS_SVH

`define WDIT_ADDR_WIDTH      16
`define WDIT_ADDR_CTRL       16'hffaa
`define WDIT_ADDR_COUNT      16'hffab

`define WDIT_KEY_COUNT       8'h5a
`define WDIT_KEY_CTRL        8'ha5

`define WDIT_BIT_FLAG        7
`define WDIT_BIT_MODE        6
`define WDIT_BIT_RUN         5
`define WDIT_BIT_RSVD        4
`define WDIT_BIT_ACTION      3
`define WDIT_CKS_HI          2
`define WDIT_CKS_LO          0

`define WDIT_CTRL_RESET      8'h10
`define WDIT_COUNT_RESET     8'h00
`define WDIT_COUNT_MAX       8'hff

`define WDIT_CLK_MHZ         200
`define WDIT_RST_HOLD_CLKS   518
`define WDIT_PRESCALE_WIDTH  12

`endif

// ==== inc/wdit_pkg.sv ====
// Types for the watchdog / interval timer.
// Assumes wdit_defs.svh is on the include path.
`include "wdit_defs.svh"
`default_nettype none

package wdit_pkg;

    // Control/status register fields
    typedef struct packed {
        logic       overflow_flag;
        logic       mode_select;
        logic       run_enable;
        logic       reserved_one;
        logic       overflow_action;
        logic [2:0] clock_divider_select;
    } wdit_ctrl_t;

    // One register bus request
    typedef struct packed {
        logic                          rd;
        logic                          wr;
        logic                          word;
        logic [`WDIT_ADDR_WIDTH-1:0]   addr;
        logic [15:0]                   wdata;
    } wdit_req_t;

    // Overflow request pulses
    typedef struct packed {
        logic chip_reset;
        logic nmi;
        logic overflow_irq;
    } wdit_event_t;

    // Internal chip reset sequencer states
    typedef enum logic [1:0] {
        WDIT_IDLE = 2'b01,
        WDIT_HOLD = 2'b10
    } wdit_rst_state_t;

endpackage

`default_nettype wire

// ==== hdl/wdit_prescaler.sv ====
// Free-running prescaler with one-cycle tick at the selected division rate.
// Assumes mclk is the peripheral clock and arst_n an asynchronous reset.
`include "wdit_defs.svh"
`default_nettype none

module wdit_prescaler #(
    parameter int WIDTH = `WDIT_PRESCALE_WIDTH
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic [2:0] sel,
    output logic            tick
);

    logic [WIDTH-1:0] div_reg;
    logic [WIDTH-1:0] div_next;
    logic             tap;
    logic             tap_reg;

    assign div_next = div_reg + {{(WIDTH-1){1'b0}}, 1'b1};

    // Free-running divider chain
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_next;
        end
    end

    always_comb begin
        case (sel)
            3'h0:    tap = div_reg[0];
            3'h1:    tap = div_reg[4];
            3'h2:    tap = div_reg[5];
            3'h3:    tap = div_reg[6];
            3'h4:    tap = div_reg[7];
            3'h5:    tap = div_reg[8];
            3'h6:    tap = div_reg[10];
            default: tap = div_reg[11];
        endcase
    end

    // Tick on falling edge of the chosen tap
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            tap_reg <= 1'b0;
        end else begin
            tap_reg <= tap;
        end
    end

    assign tick = tap_reg & ~tap;

endmodule

`default_nettype wire

// ==== hdl/wdit_timer.sv ====
// Watchdog / interval timer: 8-bit counter, control/status register,
// password-protected word writes, byte reads, overflow request pulses.
// Assumes the processor bus is synchronous to mclk, one access per cycle.
`include "wdit_defs.svh"
`default_nettype none

module wdit_timer #(
    parameter int RST_HOLD_CLKS = `WDIT_RST_HOLD_CLKS
) (
    input  wire logic                  mclk,
    input  wire logic                  arst_n,
    input  wire logic                  standby,
    input  wire wdit_pkg::wdit_req_t   req,
    output logic [7:0]                 rdata,
    output logic                       overflow_irq,
    output logic                       nmi_req,
    output logic                       chip_reset,
    output logic                       chip_reset_hold
);

    localparam int HOLD_W = $clog2(RST_HOLD_CLKS + 1);
    localparam logic [HOLD_W-1:0] HOLD_LAST = HOLD_W'(RST_HOLD_CLKS - 1);

    wdit_pkg::wdit_ctrl_t        ctrl_reg;
    logic [7:0]                  count_reg;
    logic [7:0]                  count_next;
    logic                        tick;
    logic                        wrap;
    logic                        wr_count;
    logic                        wr_ctrl;
    logic                        flag_seen_reg;
    logic [7:0]                  rdata_reg;
    wdit_pkg::wdit_event_t       event_reg;
    wdit_pkg::wdit_rst_state_t   rst_state_reg;
    logic [HOLD_W-1:0]           hold_cnt_reg;
    logic                        hold_reg;

    wdit_prescaler #(
        .WIDTH (`WDIT_PRESCALE_WIDTH)
    ) u_prescaler (
        .mclk   (mclk),
        .arst_n (arst_n),
        .sel    (ctrl_reg.clock_divider_select),
        .tick   (tick)
    );

    assign wr_count = req.wr & req.word & (req.addr == `WDIT_ADDR_CTRL)
                      & (req.wdata[15:8] == `WDIT_KEY_COUNT);
    assign wr_ctrl  = req.wr & req.word & (req.addr == `WDIT_ADDR_CTRL)
                      & (req.wdata[15:8] == `WDIT_KEY_CTRL);

    // Count only on tick while running
    assign wrap       = ctrl_reg.run_enable & tick & (count_reg == `WDIT_COUNT_MAX) & ~wr_count & ~standby;
    assign count_next = count_reg + 8'h01;

    // Counter
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg <= `WDIT_COUNT_RESET;
        end else if (standby || !ctrl_reg.run_enable) begin
            count_reg <= `WDIT_COUNT_RESET;
        end else if (wr_count) begin
            count_reg <= req.wdata[7:0];
        end else if (tick) begin
            count_reg <= count_next;
        end
    end

    // Flag read arm: flag seen set by a read of the control register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flag_seen_reg <= 1'b0;
        end else if (standby || !ctrl_reg.overflow_flag) begin
            flag_seen_reg <= 1'b0;
        end else if (req.rd && req.addr == `WDIT_ADDR_CTRL) begin
            flag_seen_reg <= 1'b1;
        end
    end

    // Control/status register
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ctrl_reg <= `WDIT_CTRL_RESET;
        end else if (standby) begin
            ctrl_reg.overflow_flag   <= 1'b0;
            ctrl_reg.mode_select     <= 1'b0;
            ctrl_reg.run_enable      <= 1'b0;
            ctrl_reg.overflow_action <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl_reg.mode_select          <= req.wdata[`WDIT_BIT_MODE];
                ctrl_reg.run_enable           <= req.wdata[`WDIT_BIT_RUN];
                ctrl_reg.overflow_action      <= req.wdata[`WDIT_BIT_ACTION];
                ctrl_reg.clock_divider_select <= req.wdata[`WDIT_CKS_HI:`WDIT_CKS_LO];
            end
            // Wrap sets flag, set beats clear
            // Clear needs prior read and a zero
            if (wrap) begin
                ctrl_reg.overflow_flag <= 1'b1;
            end else if (wr_ctrl && flag_seen_reg && !req.wdata[`WDIT_BIT_FLAG]) begin
                ctrl_reg.overflow_flag <= 1'b0;
            end
            ctrl_reg.reserved_one <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rdata_reg <= 8'h00;
        end else if (req.rd && req.addr == `WDIT_ADDR_CTRL) begin
            rdata_reg <= ctrl_reg;
        end else if (req.rd && req.addr == `WDIT_ADDR_COUNT) begin
            rdata_reg <= count_reg;
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            event_reg <= '0;
        end else begin
            event_reg.overflow_irq <= wrap & ~ctrl_reg.mode_select;
            event_reg.nmi        <= wrap & ctrl_reg.mode_select & ~ctrl_reg.overflow_action;
            event_reg.chip_reset <= wrap & ctrl_reg.mode_select & ctrl_reg.overflow_action;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rst_state_reg <= wdit_pkg::WDIT_IDLE;
            hold_cnt_reg  <= '0;
            hold_reg      <= 1'b0;
        end else begin
            case (rst_state_reg)
                wdit_pkg::WDIT_IDLE: begin
                    if (wrap && ctrl_reg.mode_select && ctrl_reg.overflow_action) begin
                        rst_state_reg <= wdit_pkg::WDIT_HOLD;
                        hold_cnt_reg  <= '0;
                        hold_reg      <= 1'b1;
                    end
                end
                wdit_pkg::WDIT_HOLD: begin
                    if (hold_cnt_reg == HOLD_LAST) begin
                        rst_state_reg <= wdit_pkg::WDIT_IDLE;
                        hold_reg      <= 1'b0;
                    end else begin
                        hold_cnt_reg <= hold_cnt_reg + HOLD_W'(1);
                    end
                end
                default: begin
                    rst_state_reg <= wdit_pkg::WDIT_IDLE;
                    hold_reg      <= 1'b0;
                end
            endcase
        end
    end

    assign rdata           = rdata_reg;
    assign overflow_irq    = event_reg.overflow_irq;
    assign nmi_req         = event_reg.nmi;
    assign chip_reset      = event_reg.chip_reset;
    assign chip_reset_hold = hold_reg;

endmodule

`default_nettype wire

// ==== verif/wdit_timer_monitor.sv ====
// Port checker for the watchdog / interval timer.
// Assumes it is bound into wdit_timer.
`include "wdit_defs.svh"
`default_nettype none
module wdit_timer_monitor #(
    parameter int RST_HOLD_CLKS = `WDIT_RST_HOLD_CLKS
) (
    input wire logic                mclk,
    input wire logic                arst_n,
    input wire logic                standby,
    input wire wdit_pkg::wdit_req_t req,
    input wire logic [7:0]          rdata,
    input wire logic                overflow_irq,
    input wire logic                nmi_req,
    input wire logic                chip_reset,
    input wire logic                chip_reset_hold
);
    logic [15:0] hold_cnt;
    default clocking @(posedge mclk); endclocking
    default disable iff (!arst_n);
    // Length of the reset hold so far
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) hold_cnt <= 16'h0000;
        else if (chip_reset) hold_cnt <= 16'h0001;
        else if (chip_reset_hold) hold_cnt <= hold_cnt + 16'h0001;
    end
    chk_irq_pulse: assert property (overflow_irq |=> !overflow_irq)
        else $error("irq too long");
    chk_nmi_pulse: assert property (nmi_req |=> !nmi_req)
        else $error("nmi too long");
    chk_one_event: assert property ($onehot0({overflow_irq, nmi_req, chip_reset}))
        else $error("two requests");
    chk_hold_start: assert property ($rose(chip_reset_hold) |-> chip_reset)
        else $error("hold without reset");
    chk_hold_len: assert property ($fell(chip_reset_hold) |-> hold_cnt == RST_HOLD_CLKS)
        else $error("hold length");
    chk_rd_idle: assert property (!$past(req.rd) |-> rdata == 8'h00)
        else $error("rdata not idle");
    chk_rsvd_one: assert property ($past(req.rd) && $past(req.addr) == `WDIT_ADDR_CTRL |-> rdata[4])
        else $error("bit 4 low");
    chk_stby_quiet: assert property (standby && $past(standby) && $past(standby, 2)
        |-> !(overflow_irq || nmi_req || chip_reset))
        else $error("request in standby");
    chk_stby_count: assert property ($past(req.rd && standby) && $past(req.addr) == `WDIT_ADDR_COUNT
        |-> rdata == 8'h00)
        else $error("count in standby");
endmodule
bind wdit_timer wdit_timer_monitor #(.RST_HOLD_CLKS(RST_HOLD_CLKS)) u_mon (
    .mclk(mclk), .arst_n(arst_n), .standby(standby), .req(req), .rdata(rdata), .overflow_irq(overflow_irq),
    .nmi_req(nmi_req), .chip_reset(chip_reset), .chip_reset_hold(chip_reset_hold));
`default_nettype wire

// ==== verif/wdit_cpu_model.sv ====
// Processor model on the timer's register bus.
// Assumes requests are taken at the rising edge of mclk.
`default_nettype none
module wdit_cpu_model (
    input  wire logic               mclk,
    input  wire logic [7:0]         rdata,
    output var wdit_pkg::wdit_req_t req
);
    // Bus idle at start
    initial req = '0;
    task automatic wr(input logic [15:0] a, input logic w, input logic [15:0] d);
        @(posedge mclk);
        req.wr <= 1'b1;
        req.word <= w;
        req.addr <= a;
        req.wdata <= d;
        @(posedge mclk);
        req.wr <= 1'b0;
        req.addr <= ~a;
        req.wdata <= ~d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d);
        @(posedge mclk);
        req.rd <= 1'b1;
        req.addr <= a;
        @(posedge mclk);
        req.rd <= 1'b0;
        req.addr <= ~a;
        @(negedge mclk);
        d = rdata;
    endtask
endmodule
`default_nettype wire

// ==== verif/watchdog_interval_timer_tb.sv ====
// Self-checking bench for the watchdog / interval timer.
// Assumes the processor model and the bound checker.
`include "wdit_defs.svh"
`default_nettype none
module watchdog_interval_timer_tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic mclk = 1'b0;
    logic arst_n = 1'b0;
    logic standby = 1'b0;
    wire wdit_pkg::wdit_req_t req;
    logic [7:0] rdata, rd_v, m_ctrl, key_v;
    logic overflow_irq, nmi_req, chip_reset, chip_reset_hold, m_arm;
    logic [2:0] ev;
    logic [31:0] rs = 32'h492b;
    logic [7:0] modes [3] = '{8'h20, 8'h60, 8'h68};
    int failures = 0;
    int samples_checked = 0;
    // Clock
    always #2.5 mclk = ~mclk;
    wdit_timer #(.RST_HOLD_CLKS(4)) i_dut (
        .mclk(mclk), .arst_n(arst_n), .standby(standby), .req(req), .rdata(rdata), .overflow_irq(overflow_irq),
        .nmi_req(nmi_req), .chip_reset(chip_reset), .chip_reset_hold(chip_reset_hold));
    wdit_cpu_model i_cpu (.mclk(mclk), .rdata(rdata), .req(req));
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic end_sim();
        $display("checks %0d failures %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] s);
        samples_checked++;
        if (s !== e) begin
            failures++;
            $display("CHECK FAILED %s exp %h got %h", n, e, s);
        end
    endtask
    // Write and update the model register
    task automatic cwr(input logic [15:0] a, input logic w, input logic [15:0] d);
        i_cpu.wr(a, w, d);
        if (w && a == `WDIT_ADDR_CTRL && d[15:8] == `WDIT_KEY_CTRL) begin
            m_ctrl = {m_ctrl[7] && !(m_arm && !d[7]), d[6:5], 1'b1, d[3:0]};
            m_arm = m_arm && m_ctrl[7];
        end
    endtask
    task automatic crd(input logic [15:0] a, input logic [7:0] e, input string n);
        i_cpu.rd(a, rd_v);
        chk(n, e, rd_v);
        if (a == `WDIT_ADDR_CTRL) m_arm = m_ctrl[7];
    endtask
    // Hang guard
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        end_sim();
    end
    // Test sequence
    initial begin
        m_ctrl = `WDIT_CTRL_RESET;
        m_arm = 1'b0;
        repeat (20) @(posedge mclk);
        arst_n <= 1'b1;
        crd(`WDIT_ADDR_CTRL, m_ctrl, "ctrl");
        crd(`WDIT_ADDR_COUNT, 8'h00, "count");
        $display("reset test done");
        for (int i = 0; i < 12; i++) begin
            rs = xs(rs);
            // Either key or a random, usually wrong, upper byte
            key_v = rs[9] ? `WDIT_KEY_CTRL : (rs[8] ? `WDIT_KEY_COUNT : rs[23:16]);
            cwr(rs[11] ? `WDIT_ADDR_CTRL : `WDIT_ADDR_COUNT, rs[10], {key_v, rs[7:0] & 8'hdf});
            crd(`WDIT_ADDR_CTRL, m_ctrl, "ctrl");
            crd(`WDIT_ADDR_COUNT, 8'h00, "count");
        end
        $display("access test done");
        for (int m = 0; m < 3; m++) begin
            cwr(`WDIT_ADDR_CTRL, 1'b1, {8'ha5, modes[m]});
            cwr(`WDIT_ADDR_CTRL, 1'b1, {8'h5a, 8'hff});
            ev = 3'b000;
            for (int i = 0; i < 16 && ev == 3'b000; i++) begin
                @(posedge mclk);
                #1 ev = {overflow_irq, nmi_req, chip_reset};
            end
            chk("event", {5'h00, 3'b100 >> m}, {5'h00, ev});
            m_ctrl[7] = 1'b1;
            cwr(`WDIT_ADDR_CTRL, 1'b1, {8'ha5, modes[m] & 8'h48});
            crd(`WDIT_ADDR_CTRL, m_ctrl, "flag");
            cwr(`WDIT_ADDR_CTRL, 1'b1, {8'ha5, modes[m] & 8'h48});
            crd(`WDIT_ADDR_CTRL, m_ctrl, "flag");
        end
        $display("overflow test done");
        cwr(`WDIT_ADDR_CTRL, 1'b1, {8'ha5, 8'h6f});
        cwr(`WDIT_ADDR_CTRL, 1'b1, {8'h5a, 8'h3c});
        crd(`WDIT_ADDR_COUNT, 8'h3c, "count");
        @(posedge mclk) standby <= 1'b1;
        crd(`WDIT_ADDR_COUNT, 8'h00, "count");
        @(posedge mclk) standby <= 1'b0;
        m_ctrl = m_ctrl & 8'h17;
        crd(`WDIT_ADDR_CTRL, m_ctrl, "ctrl");
        $display("standby test done");
        // Reset in mid-run clears clock select and count
        cwr(`WDIT_ADDR_CTRL, 1'b1, {8'ha5, 8'h27});
        cwr(`WDIT_ADDR_CTRL, 1'b1, {8'h5a, 8'h5c});
        @(posedge mclk) arst_n <= 1'b0;
        repeat (3) @(posedge mclk);
        arst_n <= 1'b1;
        m_ctrl = `WDIT_CTRL_RESET;
        m_arm = 1'b0;
        crd(`WDIT_ADDR_CTRL, m_ctrl, "ctrl");
        crd(`WDIT_ADDR_COUNT, 8'h00, "count");
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
`default_nettype wire
